// *** iopl_pkg.sv ***
// Overview of operation
// - while the global pull-up disable bit is set, no port pin has its pull-up on, whatever its direction and latch bits say.
// - the global pull-up disable bit is bit 4 of the core control register, read/write, reset to zero.
// - an enabled timer five compare output A, B or C drives port L bit 3, 4 or 5 in place of the latch.
// - no port L pin has pull-up, direction or input gating overridden, and bits 7 and 6 have no alternate use.
// - the sampled level of port L bit 2 is the external count source of timer five.
// - the sampled level of port L bit 1 is the capture trigger of timer five.
// - the sampled level of port L bit 0 is the capture trigger of timer four.
// - every output latch register is eight bits, read/write, reset to zero; port A's sits at 0x02.
// - every direction register is eight bits, read/write, reset to zero (all inputs); port A's sits at 0x01.
// - every pin input register returns the sampled pin levels; port A's sits at 0x00.
// - every register except port L's answers at its I/O index and again at that index plus 0x20.
package iopl_pkg;

  // ****************************************
  // slots, kinds and register indices
  // ****************************************
  localparam int IOPL_NSLOT = 6;
  localparam int IOPL_IDX_W = 10;
  localparam int IOPL_ADDR_LSB = 2;
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam logic [2:0] PORT_L = 3'h5;
  localparam logic [1:0] KIND_INPUT = 2'h0;
  localparam logic [1:0] KIND_DIRECTION = 2'h1;
  localparam logic [1:0] KIND_LATCH = 2'h2;
  localparam logic [1:0] KIND_CORE = 2'h3;
  localparam logic [9:0] IDX_PORT_A_INPUT_LEVELS = 10'h000;
  localparam logic [9:0] IDX_PORT_A_DIRECTION = 10'h001;
  localparam logic [9:0] IDX_PORT_A_OUTPUT_LATCH = 10'h002;
  localparam logic [9:0] IDX_PORT_B_INPUT_LEVELS = 10'h003;
  localparam logic [9:0] IDX_PORT_B_DIRECTION = 10'h004;
  localparam logic [9:0] IDX_PORT_B_OUTPUT_LATCH = 10'h005;
  localparam logic [9:0] IDX_PORT_C_INPUT_LEVELS = 10'h006;
  localparam logic [9:0] IDX_PORT_C_DIRECTION = 10'h007;
  localparam logic [9:0] IDX_PORT_C_OUTPUT_LATCH = 10'h008;
  localparam logic [9:0] IDX_PORT_D_INPUT_LEVELS = 10'h009;
  localparam logic [9:0] IDX_PORT_D_DIRECTION = 10'h00a;
  localparam logic [9:0] IDX_PORT_D_OUTPUT_LATCH = 10'h00b;
  localparam logic [9:0] IDX_PORT_E_INPUT_LEVELS = 10'h00c;
  localparam logic [9:0] IDX_PORT_E_DIRECTION = 10'h00d;
  localparam logic [9:0] IDX_PORT_E_OUTPUT_LATCH = 10'h00e;
  localparam logic [9:0] IDX_CORE_CONTROL = 10'h035;
  localparam logic [9:0] IDX_PORT_L_INPUT_LEVELS = 10'h070;
  localparam logic [9:0] IDX_PORT_L_DIRECTION = 10'h071;
  localparam logic [9:0] IDX_PORT_L_OUTPUT_LATCH = 10'h072;
  localparam logic [9:0] IDX_DATA_ALIAS = 10'h020;
  localparam logic [9:0] IDX_ALIAS_LIMIT = 10'h060;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CORE_SCAN_BIT = 7;
  localparam int CORE_PULLUP_OFF_BIT = 4;
  localparam int CORE_VSEL_BIT = 1;
  localparam int CORE_VCE_BIT = 0;
  localparam logic [7:0] CORE_WRITABLE_MASK = 8'h93;
  localparam logic [7:0] CORE_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] SAMPLE_RESET = 8'h00;
  localparam int L_CMP_A_BIT = 3;
  localparam int L_CMP_B_BIT = 4;
  localparam int L_CMP_C_BIT = 5;
  localparam int L_COUNT_BIT = 2;
  localparam int L_CAP5_BIT = 1;
  localparam int L_CAP4_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // {hit, slot, kind}
  typedef logic [5:0] iopl_sel_t;

  typedef enum logic [3:0] {
    WR_IDLE = 4'h1,
    WR_HAVE_ADDR = 4'h2,
    WR_HAVE_DATA = 4'h4,
    WR_RESP = 4'h8
  } iopl_wr_state_e;

endpackage

// *** iopl_pad_bank.sv ***
`timescale 1ns/1ps
module iopl_pad_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] output_latch,
  input wire logic [7:0] direction,
  input wire logic global_pullup_off,
  input wire logic [7:0] pin_value_override_enable,
  input wire logic [7:0] pin_value_override_value,
  input wire logic [7:0] pin_level,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pad_pullup,
  output logic [7:0] sampled_pin_value
);
  import iopl_pkg::*;

  // ****************************************
  // driver side
  // ****************************************
  // override only replaces the value; direction stays with software
  assign pad_out = (pin_value_override_enable & pin_value_override_value) |
                   (~pin_value_override_enable & output_latch);
  assign pad_oe = direction;
  // pull-up only on an input with latch one, and never when disabled globally
  assign pad_pullup = ~direction & output_latch & {8{~global_pullup_off}};

  // ****************************************
  // input side
  // ****************************************
  // pins are synchronous already, so one sampling stage is enough
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sampled_pin_value <= SAMPLE_RESET;
    end else begin
      sampled_pin_value <= pin_level;
    end
  end

endmodule

// *** iopl_port_l_route.sv ***
`timescale 1ns/1ps
module iopl_port_l_route (
  input wire logic timer_five_compare_en_a,
  input wire logic timer_five_compare_en_b,
  input wire logic timer_five_compare_en_c,
  input wire logic timer_five_compare_out_a,
  input wire logic timer_five_compare_out_b,
  input wire logic timer_five_compare_out_c,
  input wire logic [7:0] sampled_pin_value,
  output logic [7:0] pin_value_override_enable,
  output logic [7:0] pin_value_override_value,
  output logic timer_five_count_source,
  output logic timer_five_capture_trigger,
  output logic timer_four_capture_trigger
);
  import iopl_pkg::*;

  // ****************************************
  // compare outputs onto bits 5..3
  // ****************************************
  // bits 7, 6 and 2..0 are never overridden
  always_comb begin
    pin_value_override_enable = 8'h00;
    pin_value_override_value = 8'h00;
    pin_value_override_enable[L_CMP_A_BIT] = timer_five_compare_en_a;
    pin_value_override_enable[L_CMP_B_BIT] = timer_five_compare_en_b;
    pin_value_override_enable[L_CMP_C_BIT] = timer_five_compare_en_c;
    pin_value_override_value[L_CMP_A_BIT] = timer_five_compare_out_a;
    pin_value_override_value[L_CMP_B_BIT] = timer_five_compare_out_b;
    pin_value_override_value[L_CMP_C_BIT] = timer_five_compare_out_c;
  end

  // ****************************************
  // sampled inputs to the timers
  // ****************************************
  assign timer_five_count_source = sampled_pin_value[L_COUNT_BIT];
  assign timer_five_capture_trigger = sampled_pin_value[L_CAP5_BIT];
  assign timer_four_capture_trigger = sampled_pin_value[L_CAP4_BIT];

endmodule

// *** iopl_top.sv ***
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module iopl_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0][7:0] port_pin_level,
  output logic [4:0][7:0] port_pin_out,
  output logic [4:0][7:0] port_pin_oe,
  output logic [4:0][7:0] port_pin_pullup,
  input wire logic [7:0] port_l_pin_level,
  output logic [7:0] port_l_pin_out,
  output logic [7:0] port_l_pin_oe,
  output logic [7:0] port_l_pin_pullup,
  input wire logic timer_five_compare_en_a,
  input wire logic timer_five_compare_en_b,
  input wire logic timer_five_compare_en_c,
  input wire logic timer_five_compare_out_a,
  input wire logic timer_five_compare_out_b,
  input wire logic timer_five_compare_out_c,
  output logic timer_five_count_source,
  output logic timer_five_capture_trigger,
  output logic timer_four_capture_trigger,
  output logic scan_port_disable,
  output logic vector_table_select,
  output logic vector_change_enable
);
  import iopl_pkg::*;

  // ****************************************
  // address decode
  // ****************************************
  // one index table, shared by the read and the write path
  function automatic iopl_sel_t decode_direct(input logic [9:0] idx);
    iopl_sel_t sel;
    sel = 6'h00;
    unique case (idx)
      IDX_PORT_A_INPUT_LEVELS: sel = {1'b1, PORT_A, KIND_INPUT};
      IDX_PORT_A_DIRECTION: sel = {1'b1, PORT_A, KIND_DIRECTION};
      IDX_PORT_A_OUTPUT_LATCH: sel = {1'b1, PORT_A, KIND_LATCH};
      IDX_PORT_B_INPUT_LEVELS: sel = {1'b1, PORT_B, KIND_INPUT};
      IDX_PORT_B_DIRECTION: sel = {1'b1, PORT_B, KIND_DIRECTION};
      IDX_PORT_B_OUTPUT_LATCH: sel = {1'b1, PORT_B, KIND_LATCH};
      IDX_PORT_C_INPUT_LEVELS: sel = {1'b1, PORT_C, KIND_INPUT};
      IDX_PORT_C_DIRECTION: sel = {1'b1, PORT_C, KIND_DIRECTION};
      IDX_PORT_C_OUTPUT_LATCH: sel = {1'b1, PORT_C, KIND_LATCH};
      IDX_PORT_D_INPUT_LEVELS: sel = {1'b1, PORT_D, KIND_INPUT};
      IDX_PORT_D_DIRECTION: sel = {1'b1, PORT_D, KIND_DIRECTION};
      IDX_PORT_D_OUTPUT_LATCH: sel = {1'b1, PORT_D, KIND_LATCH};
      IDX_PORT_E_INPUT_LEVELS: sel = {1'b1, PORT_E, KIND_INPUT};
      IDX_PORT_E_DIRECTION: sel = {1'b1, PORT_E, KIND_DIRECTION};
      IDX_PORT_E_OUTPUT_LATCH: sel = {1'b1, PORT_E, KIND_LATCH};
      IDX_CORE_CONTROL: sel = {1'b1, PORT_A, KIND_CORE};
      IDX_PORT_L_INPUT_LEVELS: sel = {1'b1, PORT_L, KIND_INPUT};
      IDX_PORT_L_DIRECTION: sel = {1'b1, PORT_L, KIND_DIRECTION};
      IDX_PORT_L_OUTPUT_LATCH: sel = {1'b1, PORT_L, KIND_LATCH};
      default: sel = 6'h00;
    endcase
    return sel;
  endfunction

  // direct index first, then the data-space copy 0x20 higher
  function automatic iopl_sel_t decode(input logic [31:0] addr);
    logic [9:0] idx;
    iopl_sel_t sel;
    idx = addr[IOPL_ADDR_LSB +: IOPL_IDX_W];
    sel = decode_direct(idx);
    if (!sel[5] && idx >= IDX_DATA_ALIAS && idx < IDX_ALIAS_LIMIT) begin
      sel = decode_direct(idx - IDX_DATA_ALIAS);
    end
    if (addr[31:IOPL_ADDR_LSB + IOPL_IDX_W] != '0) begin
      sel = 6'h00;
    end
    return sel;
  endfunction

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] output_latch [IOPL_NSLOT];
  logic [7:0] direction [IOPL_NSLOT];
  logic [7:0] sampled_pin_value [IOPL_NSLOT];
  logic [7:0] core_control;
  logic global_pullup_off;

  // ****************************************
  // write channel
  // ****************************************
  iopl_wr_state_e wr_state;
  iopl_wr_state_e next_wr_state;
  logic [31:0] held_awaddr;
  logic [31:0] held_wdata;
  logic [3:0] held_wstrb;
  logic aw_hs;
  logic w_hs;
  logic wr_fire;
  logic [31:0] eff_addr;
  logic [31:0] eff_data;
  logic [3:0] eff_strb;
  iopl_sel_t wr_sel;
  logic wr_do;
  logic [1:0] bresp_q;

  // address and data may come in either order, or together
  assign s_axi_awready = (wr_state == WR_IDLE) || (wr_state == WR_HAVE_DATA);
  assign s_axi_wready = (wr_state == WR_IDLE) || (wr_state == WR_HAVE_ADDR);
  assign s_axi_bvalid = (wr_state == WR_RESP);
  assign s_axi_bresp = bresp_q;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign eff_addr = aw_hs ? s_axi_awaddr : held_awaddr;
  assign eff_data = w_hs ? s_axi_wdata : held_wdata;
  assign eff_strb = w_hs ? s_axi_wstrb : held_wstrb;
  assign wr_fire = (wr_state == WR_IDLE && aw_hs && w_hs) ||
                   (wr_state == WR_HAVE_ADDR && w_hs) ||
                   (wr_state == WR_HAVE_DATA && aw_hs);
  assign wr_sel = decode(eff_addr);
  // only byte lane 0 carries register bits
  assign wr_do = wr_fire && wr_sel[5] && eff_strb[0];

  // write sequencing
  always_comb begin
    next_wr_state = wr_state;
    unique case (wr_state)
      WR_IDLE: begin
        if (wr_fire) begin
          next_wr_state = WR_RESP;
        end else if (aw_hs) begin
          next_wr_state = WR_HAVE_ADDR;
        end else if (w_hs) begin
          next_wr_state = WR_HAVE_DATA;
        end
      end
      WR_HAVE_ADDR: begin
        if (wr_fire) begin
          next_wr_state = WR_RESP;
        end
      end
      WR_HAVE_DATA: begin
        if (wr_fire) begin
          next_wr_state = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = WR_IDLE;
        end
      end
      default: next_wr_state = WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_IDLE;
    end else begin
      wr_state <= next_wr_state;
    end
  end

  // holding registers for whichever half arrives first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_awaddr <= 32'h0000_0000;
      held_wdata <= 32'h0000_0000;
      held_wstrb <= 4'h0;
    end else begin
      if (aw_hs) begin
        held_awaddr <= s_axi_awaddr;
      end
      if (w_hs) begin
        held_wdata <= s_axi_wdata;
        held_wstrb <= s_axi_wstrb;
      end
    end
  end

  // unmapped writes are dropped but still answered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bresp_q <= wr_sel[5] ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ****************************************
  // port registers
  // ****************************************
  // pins follow these flops combinationally, so a write shows at its own edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < IOPL_NSLOT; i++) begin
        output_latch[i] <= LATCH_RESET;
      end
    end else if (wr_do && wr_sel[1:0] == KIND_LATCH) begin
      output_latch[wr_sel[4:2]] <= eff_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < IOPL_NSLOT; i++) begin
        direction[i] <= DIRECTION_RESET;
      end
    end else if (wr_do && wr_sel[1:0] == KIND_DIRECTION) begin
      direction[wr_sel[4:2]] <= eff_data[7:0];
    end
  end

  // reserved bits never take a one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_control <= CORE_RESET;
    end else if (wr_do && wr_sel[1:0] == KIND_CORE) begin
      core_control <= eff_data[7:0] & CORE_WRITABLE_MASK;
    end
  end

  assign global_pullup_off = core_control[CORE_PULLUP_OFF_BIT];
  assign scan_port_disable = core_control[CORE_SCAN_BIT];
  assign vector_table_select = core_control[CORE_VSEL_BIT];
  assign vector_change_enable = core_control[CORE_VCE_BIT];

  // ****************************************
  // read channel
  // ****************************************
  iopl_sel_t rd_sel;
  logic ar_hs;
  logic [7:0] rd_byte;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign rd_sel = decode(s_axi_araddr);

  // read mux; input registers show the sampled pins, not the latch
  always_comb begin
    rd_byte = 8'h00;
    if (rd_sel[5]) begin
      unique case (rd_sel[1:0])
        KIND_INPUT: rd_byte = sampled_pin_value[rd_sel[4:2]];
        KIND_DIRECTION: rd_byte = direction[rd_sel[4:2]];
        KIND_LATCH: rd_byte = output_latch[rd_sel[4:2]];
        KIND_CORE: rd_byte = core_control;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_sel[5] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // pad banks
  // ****************************************
  logic [7:0] l_override_enable;
  logic [7:0] l_override_value;

  iopl_port_l_route u_port_l_route (
    .timer_five_compare_en_a(timer_five_compare_en_a),
    .timer_five_compare_en_b(timer_five_compare_en_b),
    .timer_five_compare_en_c(timer_five_compare_en_c),
    .timer_five_compare_out_a(timer_five_compare_out_a),
    .timer_five_compare_out_b(timer_five_compare_out_b),
    .timer_five_compare_out_c(timer_five_compare_out_c),
    .sampled_pin_value(sampled_pin_value[PORT_L]),
    .pin_value_override_enable(l_override_enable),
    .pin_value_override_value(l_override_value),
    .timer_five_count_source(timer_five_count_source),
    .timer_five_capture_trigger(timer_five_capture_trigger),
    .timer_four_capture_trigger(timer_four_capture_trigger)
  );

  // ports a..e carry no alternate function in this block
  for (genvar g = 0; g < IOPL_NSLOT; g++) begin : g_bank
    if (g == int'(PORT_L)) begin : g_l
      iopl_pad_bank u_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .output_latch(output_latch[g]),
        .direction(direction[g]),
        .global_pullup_off(global_pullup_off),
        .pin_value_override_enable(l_override_enable),
        .pin_value_override_value(l_override_value),
        .pin_level(port_l_pin_level),
        .pad_out(port_l_pin_out),
        .pad_oe(port_l_pin_oe),
        .pad_pullup(port_l_pin_pullup),
        .sampled_pin_value(sampled_pin_value[g])
      );
    end else begin : g_plain
      iopl_pad_bank u_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .output_latch(output_latch[g]),
        .direction(direction[g]),
        .global_pullup_off(global_pullup_off),
        .pin_value_override_enable(8'h00),
        .pin_value_override_value(8'h00),
        .pin_level(port_pin_level[g]),
        .pad_out(port_pin_out[g]),
        .pad_oe(port_pin_oe[g]),
        .pad_pullup(port_pin_pullup[g]),
        .sampled_pin_value(sampled_pin_value[g])
      );
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_core_write;
    wr_do && wr_sel[1:0] == KIND_CORE;
  endsequence

  sequence s_latch_a_write;
    wr_do && wr_sel[4:2] == PORT_A && wr_sel[1:0] == KIND_LATCH;
  endsequence

  sequence s_dir_a_write;
    wr_do && wr_sel[4:2] == PORT_A && wr_sel[1:0] == KIND_DIRECTION;
  endsequence

  sequence s_pin_a_read;
    ar_hs && rd_sel == {1'b1, PORT_A, KIND_INPUT};
  endsequence

  AST_PULLUP_OFF: assert property (global_pullup_off |->
    (port_l_pin_pullup == 8'h00 && port_pin_pullup == '0))
    else $error("pull-up on while globally disabled");

  AST_PULLUP_BIT: assert property (s_core_write |=>
    global_pullup_off == $past(eff_data[CORE_PULLUP_OFF_BIT]))
    else $error("pull-up disable bit did not follow write");

  AST_CORE_RESERVED: assert property ((core_control & ~CORE_WRITABLE_MASK) == 8'h00)
    else $error("reserved core control bit set");

  AST_CMP_A: assert property (timer_five_compare_en_a |->
    port_l_pin_out[L_CMP_A_BIT] == timer_five_compare_out_a)
    else $error("compare A not on port L bit 3");

  AST_CMP_C: assert property (!timer_five_compare_en_c |->
    port_l_pin_out[L_CMP_C_BIT] == output_latch[PORT_L][L_CMP_C_BIT])
    else $error("port L bit 5 not from latch");

  AST_L_NO_DIR_OVERRIDE: assert property (port_l_pin_oe == direction[PORT_L])
    else $error("port L direction overridden");

  AST_COUNT_SOURCE: assert property (##1 timer_five_count_source ==
    $past(port_l_pin_level[L_COUNT_BIT]))
    else $error("count source not sampled bit 2");

  AST_CAPTURE_FIVE: assert property (##1 timer_five_capture_trigger ==
    $past(port_l_pin_level[L_CAP5_BIT]))
    else $error("timer five capture not sampled bit 1");

  AST_CAPTURE_FOUR: assert property (##1 timer_four_capture_trigger ==
    $past(port_l_pin_level[L_CAP4_BIT]))
    else $error("timer four capture not sampled bit 0");

  AST_LATCH_WRITE: assert property (s_latch_a_write |=>
    (output_latch[PORT_A] == $past(eff_data[7:0]) &&
     port_pin_out[PORT_A] == $past(eff_data[7:0])))
    else $error("port A latch write not on pins");

  AST_DIR_WRITE: assert property (s_dir_a_write |=>
    port_pin_oe[PORT_A] == $past(eff_data[7:0]))
    else $error("port A direction write not on enables");

  AST_PIN_READ: assert property (s_pin_a_read |=>
    (s_axi_rvalid && s_axi_rdata[7:0] == $past(sampled_pin_value[PORT_A])))
    else $error("port A input read wrong");

  AST_ALIAS: assert property ((ar_hs && s_axi_araddr[31:IOPL_ADDR_LSB] ==
    30'(IDX_CORE_CONTROL + IDX_DATA_ALIAS)) |=>
    (s_axi_rresp == RESP_OKAY && s_axi_rdata[7:0] == $past(core_control)))
    else $error("data-space copy of core control wrong");

endmodule

// *** iopl_far_side.sv ***
`timescale 1ns/1ps
module iopl_far_side #(parameter int W = 8) (
  input wire logic [W-1:0] pin_drive,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pin_pullup,
  input wire logic [W-1:0] ext_level,
  output logic [W-1:0] pin_level
);
  // a driven pin reads back its drive; a released pin floats to pull-up or outside level
  assign pin_level = (pin_oe & pin_drive) | (~pin_oe & (pin_pullup | ext_level));
endmodule

// *** iopl_top_test.sv ***
`timescale 1ns/1ps
module iopl_top_test;
  import iopl_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0][7:0] port_pin_level, port_pin_out, port_pin_oe, port_pin_pullup;
  logic [7:0] port_l_pin_level, port_l_pin_out, port_l_pin_oe, port_l_pin_pullup;
  logic timer_five_compare_en_a = 1'b0, timer_five_compare_en_b = 1'b0;
  logic timer_five_compare_en_c = 1'b0, timer_five_compare_out_a = 1'b0;
  logic timer_five_compare_out_b = 1'b0, timer_five_compare_out_c = 1'b0;
  logic timer_five_count_source, timer_five_capture_trigger, timer_four_capture_trigger;
  logic scan_port_disable, vector_table_select, vector_change_enable;
  logic [39:0] ext_ae = '0;
  logic [7:0] ext_l = 8'h00;
  int err_total = 0, checked = 0;
  always #20 aclk = ~aclk;
  iopl_top i_dut (.*);
  iopl_far_side #(.W(40)) i_pins_ae (.pin_drive(port_pin_out), .pin_oe(port_pin_oe),
    .pin_pullup(port_pin_pullup), .ext_level(ext_ae), .pin_level(port_pin_level));
  iopl_far_side i_pins_l (.pin_drive(port_l_pin_out), .pin_oe(port_l_pin_oe),
    .pin_pullup(port_l_pin_pullup), .ext_level(ext_l), .pin_level(port_l_pin_level));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  // handshakes judged at the falling edge, so no race with the design's own edge
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid & !ta) | (s_axi_wvalid & !tw));
    do @(negedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string n);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    rsp = s_axi_rresp;
    chk(n, e, s_axi_rdata);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog at 2500 cycles, far beyond the fewer than a hundred cycles the sequence needs
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(32'hd4, 32'h0, "core");
    rdc(32'h88, 32'h0, "latch_a");
    wr(32'hd4, 8'hff);
    chk("bresp", 32'h0, rsp);
    chk("core_out", 32'h7, {scan_port_disable, vector_table_select, vector_change_enable});
    rdc(32'h154, 32'h93, "core");
    wr(32'h08, 8'ha5);
    chk("out_a", 32'ha5, port_pin_out[0]);
    wr(32'h84, 8'h0f);
    chk("oe_a", 32'h0f, port_pin_oe[0]);
    chk("pu_a", 32'h0, port_pin_pullup[0]);
    wr(32'hd4, 8'h00);
    chk("pu_a", 32'ha0, port_pin_pullup[0]);
    rdc(32'h0, 32'ha5, "in_a");
    wr(32'h1c4, 8'hff);
    {timer_five_compare_en_c, timer_five_compare_en_b, timer_five_compare_en_a} <= 3'h7;
    {timer_five_compare_out_c, timer_five_compare_out_b, timer_five_compare_out_a} <= 3'h5;
    @(negedge aclk);
    chk("out_l", 32'h28, port_l_pin_out);
    chk("oe_l", 32'hff, port_l_pin_oe);
    wr(32'h1c4, 8'h00);
    ext_l <= 8'h05;
    repeat (3) @(negedge aclk);
    chk("tmr", 32'h5, {timer_five_count_source, timer_five_capture_trigger,
      timer_four_capture_trigger});
    @(posedge aclk);
    ext_l <= 8'h02;
    repeat (3) @(negedge aclk);
    chk("tmr", 32'h2, {timer_five_count_source, timer_five_capture_trigger,
      timer_four_capture_trigger});
    rdc(32'h3fc, 32'h0, "unmapped");
    chk("rresp", 32'h2, rsp);
    wr(32'h3fc, 8'hff);
    chk("bresp", 32'h2, rsp);
    // latch ones on inputs: pull-ups on, compare bits still take the timer values
    wr(32'h1c8, 8'hff);
    chk("pu_l", 32'hff, port_l_pin_pullup);
    chk("out_l", 32'hef, port_l_pin_out);
    wr(32'hd4, 8'h10);
    chk("pu_l", 32'h0, port_l_pin_pullup);
    print_verdict();
  end
endmodule
